// ---- hdl/rtc_cfg_pkg.sv ----
package rtc_cfg_pkg;

  // register offsets
  localparam logic [7:0] ADDR_STATUS = 8'h07;
  localparam logic [7:0] ADDR_INT_CTRL = 8'h08;
  localparam logic [7:0] ADDR_SUPPLY = 8'h09;
  localparam logic [7:0] ADDR_BATT = 8'h0a;
  localparam logic [7:0] ADDR_TRIM = 8'h0b;

  // status register fields
  localparam int STAT_ALARM_BIT = 4;
  localparam int STAT_SUPPLY_BIT = 3;
  localparam int STAT_WARN_BIT = 2;
  localparam int STAT_CRIT_BIT = 1;

  // interrupt_output_ctrl fields
  localparam int INT_AUTOCLR_BIT = 7;
  localparam int INT_MODE_BIT = 5;
  localparam int INT_BATDIS_BIT = 4;
  localparam int INT_FSEL_LSB = 0;

  // supply_monitor_ctrl, battery_monitor_ctrl, initial_trim fields
  localparam int SUP_TSCLR_BIT = 7;
  localparam int SUP_LEVEL_LSB = 0;
  localparam int BAT_DISC_BIT = 6;
  localparam int BAT_WARN_LSB = 3;
  localparam int BAT_CRIT_LSB = 0;
  localparam int TRIM_COARSE_LSB = 6;
  localparam int TRIM_FINE_LSB = 0;

  // reset values and the reserved level code
  localparam logic [7:0] INT_CTRL_RST = 8'h00;
  localparam logic [2:0] LEVEL_RST = 3'h0;
  localparam logic [1:0] COARSE_TRIM_RST = 2'h0;
  localparam logic [5:0] FINE_TRIM_RST = 6'h20;
  localparam logic [2:0] LEVEL_RESERVED = 3'h7;

  // coarse trim codes
  localparam logic [1:0] TRIM_NONE = 2'h0;
  localparam logic [1:0] TRIM_FAST = 2'h1;
  localparam logic [1:0] TRIM_ZERO = 2'h2;
  localparam logic [1:0] TRIM_SLOW = 2'h3;

  // frequency select codes and their divider bit numbers
  localparam logic [3:0] FSEL_OFF = 4'h0;
  localparam logic [3:0] FSEL_32K = 4'h1;
  localparam logic [3:0] FSEL_4K = 4'h2;
  localparam logic [3:0] FSEL_1K = 4'h3;
  localparam logic [4:0] FSEL_4K_BIT = 5'h02;
  localparam logic [4:0] FSEL_1K_BIT = 5'h04;
  localparam logic [4:0] FSEL_LOW_OFS = 5'h04;

  // timebase
  localparam int OSC_HZ = 32768;
  localparam int DIV_W = 20;
  localparam int SEC_W = 15;
  localparam int PULSE_MS = 250;
  localparam int PULSE_W = 14;
  localparam logic [PULSE_W-1:0] PULSE_TICKS = PULSE_W'(OSC_HZ * PULSE_MS / 1000);

endpackage : rtc_cfg_pkg

// ---- hdl/timebase_if.sv ----
`timescale 1ns/1ns
`default_nettype none
interface timebase_if;
  logic tick;
  logic osc_level;
  logic [rtc_cfg_pkg::DIV_W-1:0] div_cnt;
  logic [1:0] trim;
  modport src (output tick, output osc_level, output div_cnt, input trim);
  modport sink (input tick, input osc_level, input div_cnt, output trim);
endinterface : timebase_if
`default_nettype wire

// ---- hdl/osc_timebase.sv ----
`timescale 1ns/1ns
`default_nettype none
module osc_timebase (
  input wire logic ref_clk_i,     // system clock
  input wire logic resetn_i,      // async reset, active low
  input wire logic osc_clk_i,     // 32.768 kHz oscillator pin
  timebase_if.src tb              // ticks and divider to the user
);
  logic osc_s1_q;
  logic osc_s2_q;
  logic osc_s3_q;
  logic [rtc_cfg_pkg::SEC_W-1:0] sec_q;
  logic [rtc_cfg_pkg::DIV_W-1:0] div_q;
  logic [rtc_cfg_pkg::DIV_W-1:0] div_d;
  logic [rtc_cfg_pkg::DIV_W-1:0] step;
  wire tick = osc_s2_q & ~osc_s3_q;
  wire sec_wrap = tick & (&sec_q);

  // trim once a second: one count in 32768 is about 30.5 ppm
  // the oscillator itself is never touched, only the count
  assign step = !sec_wrap ? rtc_cfg_pkg::DIV_W'(1) :
                (tb.trim == rtc_cfg_pkg::TRIM_FAST) ? rtc_cfg_pkg::DIV_W'(2) :
                (tb.trim == rtc_cfg_pkg::TRIM_SLOW) ? rtc_cfg_pkg::DIV_W'(0) :
                rtc_cfg_pkg::DIV_W'(1);
  assign div_d = tick ? div_q + step : div_q;

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      osc_s1_q <= 1'b0;
      osc_s2_q <= 1'b0;
      osc_s3_q <= 1'b0;
      sec_q <= '0;
      div_q <= '0;
    end
    else
    begin
      osc_s1_q <= osc_clk_i;
      osc_s2_q <= osc_s1_q;
      osc_s3_q <= osc_s2_q;
      sec_q <= tick ? sec_q + rtc_cfg_pkg::SEC_W'(1) : sec_q;
      div_q <= div_d;
    end
  end

  assign tb.tick = tick;
  assign tb.osc_level = osc_s2_q;
  assign tb.div_cnt = div_q;
endmodule : osc_timebase
`default_nettype wire

// ---- hdl/rtc_output_and_supply_monitor_cfg.sv ----
// Notes on behaviour
// - pulse mode: alarm match drives interrupt low for 250 ms
// - standard mode: interrupt held low until alarm flag cleared
// - standard mode is single-shot; pulse mode retriggers on every match
// - battery output disable gates frequency and interrupt outputs on battery
// - frequency select zero turns the frequency output off
// - codes 1..3 give 32768/4096/1024 Hz, 4..15 give 64 Hz halving to 1/32
// - writing timestamp clear 1 clears both switchover time stamps
// - brownout level field picks one of six supply trip levels
// - supply below level sets supply-low flag and drives low-supply reset low
// - battery disconnect isolates battery; cleared when main supply returns
// - warning level field picks one of seven battery trip levels
// - critical level field picks one of seven battery trip levels
// - coarse trim: none, +30.5 ppm, 0 ppm, -30.5 ppm
// - digital trim skips or inserts timebase counts, oscillator untouched
// - digital plus analog trim span +62.5 to -61.5 ppm
// - writing alarm flag can only clear it
// - auto-clear resets alarm, supply-low and battery flags after status read
// - supply-low self-clears above level; detection only on main supply
`timescale 1ns/1ns
`default_nettype none
module rtc_output_and_supply_monitor_cfg #(
  parameter logic [rtc_cfg_pkg::PULSE_W-1:0] PULSE_TICKS = rtc_cfg_pkg::PULSE_TICKS
) (
  input wire logic ref_clk_i,                 // 100 MHz clock
  input wire logic resetn_i,                  // async reset, active low
  input wire logic [7:0] reg_addr_i,          // register address
  input wire logic [7:0] reg_wdata_i,         // write data
  input wire logic reg_wr_i,                  // write strobe
  input wire logic reg_rd_i,                  // read strobe
  output logic [7:0] reg_rdata_o,             // read data, cycle after strobe
  input wire logic osc_clk_i,                 // 32.768 kHz timebase pin
  input wire logic on_battery_i,              // battery supply active
  input wire logic vdd_low_i,                 // supply below brownout level
  input wire logic batt_warn_low_i,           // battery below warning level
  input wire logic batt_crit_low_i,           // battery below critical level
  input wire logic alarm_match_i,             // alarm match pulse, same clock
  output logic alarm_irq_n_o,                 // alarm interrupt, active low
  output logic freq_out_pin_o,                // frequency output
  output logic low_supply_reset_n_o,          // low-supply reset, active low
  output logic battery_disconnect_o,          // battery isolated
  output logic timestamp_clear_o,             // clear both time stamps, pulse
  output logic [2:0] brownout_level_sel_o,    // supply trip level code
  output logic [2:0] batt_warn_level_sel_o,   // first battery trip level code
  output logic [2:0] batt_crit_level_sel_o,   // second battery trip level code
  output logic [5:0] fine_analog_trim_o       // analog trim code
);
  timebase_if tb ();

  osc_timebase u_timebase (
    .ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i),
    .osc_clk_i(osc_clk_i),
    .tb(tb)
  );

  // async pins: battery, supply low, warn low, crit low
  logic [3:0] pin_s1_q;
  logic [3:0] pin_s2_q;
  logic on_batt_prev_q;
  wire on_batt = pin_s2_q[3];
  wire vdd_low = pin_s2_q[2];
  wire warn_low = pin_s2_q[1];
  wire crit_low = pin_s2_q[0];

  logic [7:0] int_ctrl_q;
  logic [2:0] brown_lvl_q;
  logic [2:0] warn_lvl_q;
  logic [2:0] crit_lvl_q;
  logic batt_disc_q;
  logic [1:0] coarse_trim_q;
  logic [5:0] fine_trim_q;
  logic alarm_q;
  logic supply_low_q;
  logic warn_q;
  logic crit_q;
  logic [rtc_cfg_pkg::PULSE_W-1:0] pulse_cnt_q;
  logic [rtc_cfg_pkg::PULSE_W-1:0] pulse_cnt_d;
  logic [7:0] rdata_d;
  logic [4:0] div_bit;

  // decode
  wire wr_status = reg_wr_i & (reg_addr_i == rtc_cfg_pkg::ADDR_STATUS);
  wire wr_int = reg_wr_i & (reg_addr_i == rtc_cfg_pkg::ADDR_INT_CTRL);
  wire wr_sup = reg_wr_i & (reg_addr_i == rtc_cfg_pkg::ADDR_SUPPLY);
  wire wr_bat = reg_wr_i & (reg_addr_i == rtc_cfg_pkg::ADDR_BATT);
  wire wr_trim = reg_wr_i & (reg_addr_i == rtc_cfg_pkg::ADDR_TRIM);
  wire rd_status = reg_rd_i & (reg_addr_i == rtc_cfg_pkg::ADDR_STATUS);

  wire pulse_mode = int_ctrl_q[rtc_cfg_pkg::INT_MODE_BIT];
  wire auto_clear = int_ctrl_q[rtc_cfg_pkg::INT_AUTOCLR_BIT];
  wire [3:0] fsel = int_ctrl_q[rtc_cfg_pkg::INT_FSEL_LSB +: 4];
  wire on_main = ~on_batt;
  wire gated = on_batt & int_ctrl_q[rtc_cfg_pkg::INT_BATDIS_BIT];
  wire autoclr = rd_status & auto_clear;
  wire main_return = on_batt_prev_q & on_main;

  wire [2:0] warn_wr = reg_wdata_i[rtc_cfg_pkg::BAT_WARN_LSB +: 3];
  wire [2:0] crit_wr = reg_wdata_i[rtc_cfg_pkg::BAT_CRIT_LSB +: 3];
  // reserved code is dropped so a stray write keeps the old level
  wire [2:0] warn_lvl_d = (wr_bat && warn_wr != rtc_cfg_pkg::LEVEL_RESERVED) ? warn_wr : warn_lvl_q;
  wire [2:0] crit_lvl_d = (wr_bat && crit_wr != rtc_cfg_pkg::LEVEL_RESERVED) ? crit_wr : crit_lvl_q;
  // brownout codes above 101 are not trip levels; keep the old one
  wire [2:0] brown_wr = reg_wdata_i[rtc_cfg_pkg::SUP_LEVEL_LSB +: 3];
  wire brown_ok = (brown_wr[2:1] != 2'b11);
  wire [2:0] brown_lvl_d = (wr_sup && brown_ok) ? brown_wr : brown_lvl_q;

  // set wins over every clear
  wire alarm_clr = (wr_status & ~reg_wdata_i[rtc_cfg_pkg::STAT_ALARM_BIT]) | autoclr;
  wire alarm_d = alarm_match_i | (alarm_q & ~alarm_clr);
  wire supply_set = vdd_low & on_main;
  wire supply_low_d = supply_set | (supply_low_q & vdd_low & ~autoclr);
  wire warn_set = warn_low & on_main;
  wire warn_d = warn_set | (warn_q & ~autoclr & ~on_main);
  wire crit_set = crit_low & on_main;
  wire crit_d = crit_set | (crit_q & ~autoclr & ~on_main);

  // disconnect drops as soon as main supply comes back
  wire batt_disc_d = main_return ? 1'b0 :
                     wr_bat ? reg_wdata_i[rtc_cfg_pkg::BAT_DISC_BIT] : batt_disc_q;

  // pulse mode restarts on every match; standard mode only follows the flag
  assign pulse_cnt_d = (alarm_match_i && pulse_mode) ? PULSE_TICKS :
                       (tb.tick && pulse_cnt_q != '0) ? pulse_cnt_q - rtc_cfg_pkg::PULSE_W'(1) :
                       pulse_cnt_q;
  wire irq_low = pulse_mode ? (pulse_cnt_q != '0) : alarm_q;
  wire irq_n_d = ~(irq_low & ~gated);

  assign div_bit = (fsel == rtc_cfg_pkg::FSEL_4K) ? rtc_cfg_pkg::FSEL_4K_BIT :
                   (fsel == rtc_cfg_pkg::FSEL_1K) ? rtc_cfg_pkg::FSEL_1K_BIT :
                   {1'b0, fsel} + rtc_cfg_pkg::FSEL_LOW_OFS;
  wire div_level = tb.div_cnt[div_bit];
  wire sel_level = (fsel == rtc_cfg_pkg::FSEL_32K) ? tb.osc_level : div_level;
  // off and gated both release the pin high, as an open-drain output would
  wire freq_out_pin_d = (gated || fsel == rtc_cfg_pkg::FSEL_OFF) ? 1'b1 : sel_level;

  // coarse step acts on the count here; fine trim only goes out to the analog part
  assign tb.trim = coarse_trim_q;

  wire [7:0] status_rd = {3'h0, alarm_q, supply_low_q, warn_q, crit_q, 1'b0};
  wire [7:0] sup_rd = {5'h00, brown_lvl_q};
  wire [7:0] bat_rd = {1'b0, batt_disc_q, warn_lvl_q, crit_lvl_q};
  wire [7:0] trim_rd = {coarse_trim_q, fine_trim_q};

  always_comb
  begin
    rdata_d = 8'h00;
    if (reg_rd_i)
    begin
      case (reg_addr_i)
        rtc_cfg_pkg::ADDR_STATUS: rdata_d = status_rd;
        rtc_cfg_pkg::ADDR_INT_CTRL: rdata_d = int_ctrl_q;
        rtc_cfg_pkg::ADDR_SUPPLY: rdata_d = sup_rd;
        rtc_cfg_pkg::ADDR_BATT: rdata_d = bat_rd;
        rtc_cfg_pkg::ADDR_TRIM: rdata_d = trim_rd;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_s1_q <= 4'h0;
      pin_s2_q <= 4'h0;
      on_batt_prev_q <= 1'b0;
    end
    else
    begin
      pin_s1_q <= {on_battery_i, vdd_low_i, batt_warn_low_i, batt_crit_low_i};
      pin_s2_q <= pin_s1_q;
      on_batt_prev_q <= on_batt;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      int_ctrl_q <= rtc_cfg_pkg::INT_CTRL_RST;
      brown_lvl_q <= rtc_cfg_pkg::LEVEL_RST;
      warn_lvl_q <= rtc_cfg_pkg::LEVEL_RST;
      crit_lvl_q <= rtc_cfg_pkg::LEVEL_RST;
      batt_disc_q <= 1'b0;
      coarse_trim_q <= rtc_cfg_pkg::COARSE_TRIM_RST;
      fine_trim_q <= rtc_cfg_pkg::FINE_TRIM_RST;
    end
    else
    begin
      int_ctrl_q <= wr_int ? reg_wdata_i : int_ctrl_q;
      brown_lvl_q <= brown_lvl_d;
      warn_lvl_q <= warn_lvl_d;
      crit_lvl_q <= crit_lvl_d;
      batt_disc_q <= batt_disc_d;
      coarse_trim_q <= wr_trim ? reg_wdata_i[rtc_cfg_pkg::TRIM_COARSE_LSB +: 2] : coarse_trim_q;
      fine_trim_q <= wr_trim ? reg_wdata_i[rtc_cfg_pkg::TRIM_FINE_LSB +: 6] : fine_trim_q;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      alarm_q <= 1'b0;
      supply_low_q <= 1'b0;
      warn_q <= 1'b0;
      crit_q <= 1'b0;
      pulse_cnt_q <= '0;
    end
    else
    begin
      alarm_q <= alarm_d;
      supply_low_q <= supply_low_d;
      warn_q <= warn_d;
      crit_q <= crit_d;
      pulse_cnt_q <= pulse_cnt_d;
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      reg_rdata_o <= 8'h00;
      alarm_irq_n_o <= 1'b1;
      freq_out_pin_o <= 1'b1;
      low_supply_reset_n_o <= 1'b1;
      timestamp_clear_o <= 1'b0;
    end
    else
    begin
      reg_rdata_o <= rdata_d;
      alarm_irq_n_o <= irq_n_d;
      freq_out_pin_o <= freq_out_pin_d;
      low_supply_reset_n_o <= ~supply_set;
      timestamp_clear_o <= wr_sup & reg_wdata_i[rtc_cfg_pkg::SUP_TSCLR_BIT];
    end
  end

  assign battery_disconnect_o = batt_disc_q;
  assign brownout_level_sel_o = brown_lvl_q;
  assign batt_warn_level_sel_o = warn_lvl_q;
  assign batt_crit_level_sel_o = crit_lvl_q;
  assign fine_analog_trim_o = fine_trim_q;

  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!resetn_i);

  property p_pulse_load;
    alarm_match_i && pulse_mode |=> pulse_cnt_q == PULSE_TICKS;
  endproperty
  a_pulse_load: assert property (p_pulse_load) else $error("pulse length not loaded");

  property p_pulse_irq;
    pulse_mode && pulse_cnt_q != '0 && !gated |=> !alarm_irq_n_o;
  endproperty
  a_pulse_irq: assert property (p_pulse_irq) else $error("pulse not driven on irq");

  property p_hold_irq;
    !pulse_mode && alarm_q && !gated |=> !alarm_irq_n_o;
  endproperty
  a_hold_irq: assert property (p_hold_irq) else $error("irq not held with flag");

  property p_gate;
    gated |=> alarm_irq_n_o && freq_out_pin_o;
  endproperty
  a_gate: assert property (p_gate) else $error("outputs active on battery");

  property p_freq_out_pin_off;
    fsel == rtc_cfg_pkg::FSEL_OFF |=> freq_out_pin_o;
  endproperty
  a_freq_out_pin_off: assert property (p_freq_out_pin_off) else $error("frequency output not off");

  property p_alarm_w1;
    wr_status && reg_wdata_i[rtc_cfg_pkg::STAT_ALARM_BIT] && !autoclr && !alarm_match_i |=> $stable(alarm_q);
  endproperty
  a_alarm_w1: assert property (p_alarm_w1) else $error("writing 1 changed alarm flag");

  property p_autoclr;
    autoclr && !alarm_match_i ##1 !alarm_match_i |-> !alarm_q;
  endproperty
  a_autoclr: assert property (p_autoclr) else $error("alarm flag not auto-cleared");

  property p_supply_low;
    vdd_low && on_main |=> supply_low_q && !low_supply_reset_n_o;
  endproperty
  a_supply_low: assert property (p_supply_low) else $error("supply low not flagged");

  property p_reconnect;
    main_return |=> !batt_disc_q;
  endproperty
  a_reconnect: assert property (p_reconnect) else $error("battery not reconnected");

  property p_stamp_clear;
    wr_sup && reg_wdata_i[rtc_cfg_pkg::SUP_TSCLR_BIT] |=> timestamp_clear_o;
  endproperty
  a_stamp_clear: assert property (p_stamp_clear) else $error("time stamp clear missed");

  property p_reserved;
    wr_bat && warn_wr == rtc_cfg_pkg::LEVEL_RESERVED |=> $stable(warn_lvl_q);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved level taken");

endmodule : rtc_output_and_supply_monitor_cfg
`default_nettype wire

// ---- verification/supply_osc_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module supply_osc_model (
  input wire logic [12:0] vdd_mv_i,  // main supply in mV
  input wire logic [12:0] vbat_mv_i, // battery in mV
  input wire logic [2:0] bo_sel_i,   // brownout level code
  input wire logic [2:0] warn_sel_i, // first battery level code
  input wire logic [2:0] crit_sel_i, // second battery level code
  output logic osc_o,                // crystal oscillator
  output logic on_batt_o,            // battery supplies the device
  output logic vdd_low_o,            // main below brownout level
  output logic warn_low_o,           // battery below first level
  output logic crit_low_o            // battery below second level
);
  // trip levels in mV; unused codes never trip
  localparam logic [12:0] BO_MV [8] = '{13'h08f7, 13'h09f6, 13'h0af5, 13'h0bf4, 13'h109a, 13'h1243, 13'h0, 13'h0};
  localparam logic [12:0] WARN_MV [8] = '{13'h084d, 13'h08f7, 13'h09f6, 13'h0af5, 13'h0bf4, 13'h109a, 13'h1243,
    13'h0};
  localparam logic [12:0] CRIT_MV [8] = '{13'h0753, 13'h07e9, 13'h08ca, 13'h09ab, 13'h0a8c, 13'h0ea6, 13'h101d,
    13'h0};
  // free running, offset so its edges never meet the system clock
  initial
  begin
    osc_o = 1'b0;
    #3;
    forever #40 osc_o = ~osc_o;
  end
  assign on_batt_o = vdd_mv_i < vbat_mv_i;
  assign vdd_low_o = vdd_mv_i < BO_MV[bo_sel_i];
  assign warn_low_o = vbat_mv_i < WARN_MV[warn_sel_i];
  assign crit_low_o = vbat_mv_i < CRIT_MV[crit_sel_i];
endmodule : supply_osc_model
`default_nettype wire

// ---- verification/test_rtc_output_and_supply_monitor_cfg.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_rtc_output_and_supply_monitor_cfg;
  localparam int pexp [6] = '{0, 8, 64, 256, 4096, 8192};
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic match = 1'b0;
  logic [12:0] vdd_mv = 13'h0ce4;
  logic [12:0] vbat_mv = 13'h0bb8;
  logic [7:0] rdata;
  logic osc, on_batt, vdd_low, warn_low, crit_low, irq_n, freq_out_pin, lsr_n, disc, tsclr;
  logic [2:0] bo_sel, warn_sel, crit_sel;
  logic [5:0] fine;
  int err_total = 0;
  int checks = 0;
  int n;

  always #5 clk = ~clk;

  rtc_output_and_supply_monitor_cfg #(.PULSE_TICKS(14'h0008)) i_dut (
    .ref_clk_i(clk), .resetn_i(rst_n), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
    .reg_rd_i(rd), .reg_rdata_o(rdata), .osc_clk_i(osc), .on_battery_i(on_batt), .vdd_low_i(vdd_low),
    .batt_warn_low_i(warn_low), .batt_crit_low_i(crit_low), .alarm_match_i(match), .alarm_irq_n_o(irq_n),
    .freq_out_pin_o(freq_out_pin), .low_supply_reset_n_o(lsr_n), .battery_disconnect_o(disc),
    .timestamp_clear_o(tsclr), .brownout_level_sel_o(bo_sel), .batt_warn_level_sel_o(warn_sel),
    .batt_crit_level_sel_o(crit_sel), .fine_analog_trim_o(fine));

  supply_osc_model i_env (.vdd_mv_i(vdd_mv), .vbat_mv_i(vbat_mv), .bo_sel_i(bo_sel), .warn_sel_i(warn_sel),
    .crit_sel_i(crit_sel), .osc_o(osc), .on_batt_o(on_batt), .vdd_low_o(vdd_low), .warn_low_o(warn_low),
    .crit_low_o(crit_low));

  task report_and_stop;
    $display("comparisons %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : cyc

  task wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(rdata, e);
  endtask : rd_chk

  task fire;
    @(posedge clk);
    match <= 1'b1;
    @(posedge clk);
    match <= 1'b0;
  endtask : fire

  task set_vdd(input logic [12:0] mv);
    @(posedge clk);
    vdd_mv <= mv;
    cyc(8);
  endtask : set_vdd

  // cycles between two rising edges of the frequency pin, 0 if none
  task per(input int lim, output int p);
    int r;
    logic prev;
    p = 0;
    r = 0;
    prev = freq_out_pin;
    for (int c = 0; c < lim && r < 2; c++)
    begin
      cyc(1);
      if (prev === 1'b0 && freq_out_pin === 1'b1)
      begin
        r++;
        p = (r == 2) ? c - p : c;
      end
      prev = freq_out_pin;
    end
    if (r < 2)
      p = 0;
  endtask : per

  // length of the next low interrupt phase in cycles
  task low_len(output int p);
    p = 0;
    for (int i = 0; i < 20 && irq_n !== 1'b0; i++)
      cyc(1);
    while (irq_n === 1'b0 && p < 200)
    begin
      cyc(1);
      p++;
    end
  endtask : low_len

  // tests need about 46k cycles, the slowest frequency codes dominate
  initial
  begin
    #900000;
    err_total++;
    report_and_stop();
  end

  initial
  begin
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    cyc(1);
    chk(irq_n, 1'b1);
    chk(freq_out_pin, 1'b1);
    chk(lsr_n, 1'b1);
    chk(fine, 6'h20);
    rd_chk(8'h08, 8'h00);
    rd_chk(8'h0a, 8'h00);
    rd_chk(8'h0b, 8'h20);
    cyc(1);
    chk(rdata, 8'h00);
    wr_reg(8'h3c, 8'hff);
    rd_chk(8'h3c, 8'h00);
    wr_reg(8'h0b, 8'h7f);
    rd_chk(8'h0b, 8'h7f);
    chk(fine, 6'h3f);
    wr_reg(8'h09, 8'h80);
    #1;
    chk(tsclr, 1'b1);
    cyc(1);
    chk(tsclr, 1'b0);
    rd_chk(8'h09, 8'h00);
    for (int c = 0; c < 16; c++)
    begin
      wr_reg(8'h08, 8'(c));
      rd_chk(8'h08, 8'(c));
    end
    $display("register test done");

    wr_reg(8'h08, 8'h00);
    per(100, n);
    chk(n, 0);
    chk(freq_out_pin, 1'b1);
    for (int c = 1; c < 6; c++)
    begin
      wr_reg(8'h08, 8'(c));
      per(20000, n);
      per(20000, n);
      chk(n, pexp[c]);
    end
    wr_reg(8'h08, 8'h11);
    set_vdd(13'h0);
    per(100, n);
    chk(n, 0);
    chk(freq_out_pin, 1'b1);
    wr_reg(8'h08, 8'h01);
    cyc(4);
    per(100, n);
    chk(n, 8);
    set_vdd(13'h0ce4);
    $display("frequency test done");

    wr_reg(8'h08, 8'h20);
    fire();
    low_len(n);
    chk(n >= 57 && n <= 75, 1);
    rd_chk(8'h07, 8'h10);
    fire();
    low_len(n);
    chk(n >= 57 && n <= 75, 1);
    wr_reg(8'h07, 8'h00);
    wr_reg(8'h08, 8'h00);
    fire();
    cyc(5);
    chk(irq_n, 1'b0);
    wr_reg(8'h07, 8'hff);
    cyc(5);
    chk(irq_n, 1'b0);
    rd_chk(8'h07, 8'h10);
    wr_reg(8'h07, 8'h00);
    cyc(3);
    chk(irq_n, 1'b1);
    rd_chk(8'h07, 8'h00);
    wr_reg(8'h08, 8'h10);
    set_vdd(13'h0);
    fire();
    cyc(5);
    chk(irq_n, 1'b1);
    set_vdd(13'h0ce4);
    chk(irq_n, 1'b0);
    wr_reg(8'h07, 8'h00);
    wr_reg(8'h08, 8'h80);
    fire();
    rd_chk(8'h07, 8'h10);
    cyc(1);
    rd_chk(8'h07, 8'h00);
    wr_reg(8'h08, 8'h00);
    $display("alarm test done");

    wr_reg(8'h09, 8'h03);
    cyc(8);
    chk(lsr_n, 1'b1);
    wr_reg(8'h09, 8'h04);
    cyc(8);
    chk(lsr_n, 1'b0);
    chk(bo_sel, 3'h4);
    rd_chk(8'h07, 8'h08);
    wr_reg(8'h09, 8'h06);
    rd_chk(8'h09, 8'h04);
    set_vdd(13'h0);
    chk(lsr_n, 1'b1);
    set_vdd(13'h0ce4);
    chk(lsr_n, 1'b0);
    wr_reg(8'h09, 8'h00);
    cyc(8);
    chk(lsr_n, 1'b1);
    rd_chk(8'h07, 8'h00);
    $display("supply test done");

    wr_reg(8'h0a, 8'h26);
    cyc(8);
    chk(warn_sel, 3'h4);
    chk(crit_sel, 3'h6);
    rd_chk(8'h07, 8'h06);
    wr_reg(8'h0a, 8'h3e);
    rd_chk(8'h0a, 8'h26);
    wr_reg(8'h0a, 8'h40);
    #1;
    chk(disc, 1'b1);
    set_vdd(13'h0);
    chk(disc, 1'b1);
    set_vdd(13'h0ce4);
    chk(disc, 1'b0);
    $display("battery test done");
    report_and_stop();
  end
endmodule : test_rtc_output_and_supply_monitor_cfg
`default_nettype wire
